// >>> i2cpc_pkg.sv
// constants, register layouts and state codes of the two-wire port control block
package i2cpc_pkg;
    // register indices; bus byte address is four times the index
    localparam logic [11:0] IDX_OWN_ADDR = 12'h4A0;
    localparam logic [11:0] IDX_RX       = 12'h4A4;
    localparam logic [11:0] IDX_TX       = 12'h4A6;
    localparam logic [11:0] IDX_BAUD     = 12'h4A8;
    localparam logic [11:0] IDX_CTRL     = 12'h4AA;
    localparam logic [11:0] IDX_STAT     = 12'h4AE;
    localparam logic [11:0] IDX_AUX      = 12'h4B0;
    // values after reset
    localparam logic [15:0] RST_TX       = 16'h0000;
    localparam logic [15:0] RST_BAUD     = 16'h0000;
    localparam logic [15:0] RST_CTRL     = 16'h0000;
    localparam logic [15:0] RST_AUX      = 16'h0000;
    localparam logic [9:0]  RST_OWN      = 10'h000;
    localparam logic [7:0]  RST_RX       = 8'h00;
    // status bit positions
    localparam int          ST_NACK      = 15;
    localparam int          ST_HBUSY     = 14;
    localparam int          ST_GCALL     = 9;
    localparam int          ST_RBF       = 1;
    localparam int          ST_TBF       = 0;
    // byte framing and address space
    localparam logic [3:0]  BIT_LAST     = 4'h7;
    localparam logic [3:0]  BIT_ACK      = 4'h8;
    localparam logic [4:0]  HDR10        = 5'h1E;
    localparam logic [3:0]  RSV_LO       = 4'h0;
    localparam logic [3:0]  RSV_HI       = 4'hF;
    localparam logic [7:0]  GCALL_BYTE   = 8'h00;

    typedef struct packed {
        logic module_on;
        logic rsv14;
        logic halt_in_idle;
        logic clock_release;
        logic strict_addr;
        logic wide_address_sel;
        logic slew_off;
        logic smbus_levels;
        logic general_call_accept;
        logic stretch_allow;
        logic ack_level;
        logic ack_sequence_go;
        logic receive_go;
        logic stop_go;
        logic restart_go;
        logic start_go;
    } i2cpc_ctrl_type;

    typedef struct packed {
        logic [12:0] rsv;
        logic        data_hold;
        logic        address_hold;
        logic        host_mode;
    } i2cpc_aux_type;

    typedef struct packed {
        logic low;
        logic oe;
    } i2cpc_pin_type;

    typedef enum logic [2:0] {
        H_IDLE    = 3'b000,
        H_START   = 3'b001,
        H_RESTART = 3'b010,
        H_STOP    = 3'b011,
        H_XFER    = 3'b100,
        H_ACK     = 3'b101
    } i2cpc_host_type;

    typedef enum logic [2:0] {
        C_IDLE  = 3'b000,
        C_ADDR  = 3'b001,
        C_ADDR2 = 3'b010,
        C_ACK   = 3'b011,
        C_RX    = 3'b100,
        C_TX    = 3'b101,
        C_TXACK = 3'b110
    } i2cpc_cli_type;
endpackage : i2cpc_pkg

// >>> i2cpc_sync.sv
// three-stage synchroniser; output moves once stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module i2cpc_sync (
    input  wire logic clk_i,   // block clock
    input  wire logic rst_i,   // synchronous reset
    input  wire logic d_i,     // asynchronous pin level
    output logic      q_o      // filtered level
);
    logic s1_r;
    logic s2_r;
    logic s3_r;

    // idle bus level is high, so reset to one
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s1_r <= 1'b1;
            s2_r <= 1'b1;
            s3_r <= 1'b1;
            q_o  <= 1'b1;
        end else begin
            s1_r <= d_i;
            s2_r <= s1_r;
            s3_r <= s2_r;
            if (s2_r == s3_r) begin
                q_o <= s3_r;
            end
        end
    end
endmodule : i2cpc_sync
`default_nettype wire

// >>> i2cpc_top.sv
// two-wire port: register file on classic wishbone, host and client bus engines
`timescale 1ns/1ps
`default_nettype none
// How it works
// R1 - transmit register holds outgoing byte in 7:0
// R2 - sixteen-bit writable baud reload value
// R3 - enable bit hands pins to the port
// R4 - halt in idle stops the port
// R5 - stretching: release frees, zero holds next low
// R6 - no stretching: zero forces clock low now
// R7 - hardware clears release bit per mode
// R8 - software waits setup time before release
// R9 - strict client NACKs reserved addresses
// R10 - strict host may send reserved addresses
// R11 - loose client acks matching reserved addresses
// R12 - width bit selects ten or seven bit
// R13 - general call accepted and event raised
// R14 - host ack sequence sends ack level
// R15 - client hold modes send ack level
// R16 - ack sequence enable runs host ack
// R17 - go bits cleared when operation completes
// R18 - receive go takes one byte, self clears
// R19 - start, restart, stop go make conditions
// R20 - baud reload counted down per phase
module i2cpc_top (
    input  wire logic        clk_i,        // 25 MHz block clock
    input  wire logic        rst_i,        // synchronous reset, active high
    input  wire logic        wb_cyc_i,     // wishbone cycle
    input  wire logic        wb_stb_i,     // wishbone strobe
    input  wire logic        wb_we_i,      // wishbone write
    input  wire logic [13:0] wb_adr_i,     // wishbone byte address
    input  wire logic [3:0]  wb_sel_i,     // wishbone byte lanes
    input  wire logic [31:0] wb_dat_i,     // wishbone write data
    output logic      [31:0] wb_dat_o,     // wishbone read data
    output logic             wb_ack_o,     // wishbone acknowledge
    input  wire logic        scl_i,        // clock pin level
    output logic             scl_o,        // clock pin drive value
    output logic             scl_oe_o,     // clock pin driven low
    input  wire logic        sda_i,        // data pin level
    output logic             sda_o,        // data pin drive value
    output logic             sda_oe_o,     // data pin driven low
    input  wire logic        cpu_idle_i,   // chip in idle mode
    output logic             pins_owned_o, // pins belong to the port
    output logic             gc_event_o    // general call received pulse
);
    import i2cpc_pkg::*;

    i2cpc_ctrl_type ctrl_r, ctrl_nxt;
    i2cpc_aux_type  aux_r;
    i2cpc_host_type h_state_r, h_state_nxt;
    i2cpc_cli_type  c_state_r, c_state_nxt, c_after_r, c_after_nxt;
    i2cpc_pin_type  scl_pin, sda_pin;
    logic [15:0] tx_r, baud_r, tmr_r, tmr_nxt, wmask;
    logic [9:0]  own_r;
    logic [7:0]  rx_r, h_sh_r, h_sh_nxt, c_sh_r, c_sh_nxt, rd_low;
    logic [3:0]  bcnt_r, bcnt_nxt, ccnt_r, ccnt_nxt;
    logic [1:0]  stp_r, stp_nxt;
    logic        h_rx_r, h_rx_nxt, h_scl_r, h_scl_nxt, h_sda_r, h_sda_nxt;
    logic        c_sda_r, c_sda_nxt, c_hold_r, c_wide_r, c_wide_nxt, c_mack_r, c_mack_nxt;
    logic        tbf_r, rbf_r, nack_r, gcs_r, ack_r;
    logic        scl_s, sda_s, scl_q, sda_q;
    logic        h_done_st, h_done_rs, h_done_sp, h_done_ak, h_done_rx, h_take, h_nack_ld;
    logic        c_rx_ld, c_take, c_gc, c_relclr;
    logic [7:0]  h_rx_val;

    // bus decode
    wire [11:0] idx     = wb_adr_i[13:2];
    wire        acc     = wb_cyc_i & wb_stb_i & ~ack_r;
    wire        wr      = acc & wb_we_i;
    wire        rd      = acc & ~wb_we_i;
    wire        hit_own = (idx == IDX_OWN_ADDR);
    wire        hit_rx  = (idx == IDX_RX);
    wire        hit_tx  = (idx == IDX_TX);
    wire        hit_brg = (idx == IDX_BAUD);
    wire        hit_ctl = (idx == IDX_CTRL);
    wire        hit_st  = (idx == IDX_STAT);
    wire        hit_aux = (idx == IDX_AUX);
    assign wmask = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

    wire run    = ctrl_r.module_on & ~(ctrl_r.halt_in_idle & cpu_idle_i); // R3 R4
    wire host   = aux_r.host_mode;
    wire h_busy = (h_state_r != H_IDLE);
    wire [15:0] stat = (16'(nack_r) << ST_NACK) | (16'(h_busy) << ST_HBUSY)
                     | (16'(gcs_r) << ST_GCALL) | (16'(rbf_r) << ST_RBF)
                     | (16'(tbf_r) << ST_TBF);
    // unmapped indices read as zero
    wire [15:0] rd_mux = hit_own ? {6'h00, own_r} :
                         hit_rx  ? {8'h00, rx_r} :
                         hit_tx  ? {8'h00, tx_r[7:0]} :
                         hit_brg ? baud_r :
                         hit_ctl ? ctrl_r :
                         hit_st  ? stat :
                         hit_aux ? aux_r : 16'h0000;
    assign rd_low = rx_r;

    function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] m,
                                          input logic [15:0] d);
        merge = (old & ~m) | (d & m);
    endfunction : merge

    i2cpc_sync u_scl_sync (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .d_i   (scl_i),
        .q_o   (scl_s)
    );
    i2cpc_sync u_sda_sync (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .d_i   (sda_i),
        .q_o   (sda_s)
    );

    // bus edges and conditions seen on the wire
    wire scl_rise  = scl_s & ~scl_q;
    wire scl_fall  = ~scl_s & scl_q;
    wire start_det = scl_s & scl_q & sda_q & ~sda_s;
    wire stop_det  = scl_s & scl_q & ~sda_q & sda_s;

    // control register: software write wins over go-bit completion,
    // hardware clear of the release bit wins over software
    always_comb begin
        ctrl_nxt = ctrl_r;
        if (h_done_st) ctrl_nxt.start_go = 1'b0;           // R17 R19
        if (h_done_rs) ctrl_nxt.restart_go = 1'b0;         // R17 R19
        if (h_done_sp) ctrl_nxt.stop_go = 1'b0;            // R17 R19
        if (h_done_ak) ctrl_nxt.ack_sequence_go = 1'b0;    // R17 R16
        if (h_done_rx) ctrl_nxt.receive_go = 1'b0;         // R17 R18
        if (wr && hit_ctl) ctrl_nxt = merge(ctrl_r, wmask, wb_dat_i[15:0]); // R3
        if (c_relclr) ctrl_nxt.clock_release = 1'b0;       // R7
    end

    // host engine: every low and high phase lasts baud_reload + 1 counts
    wire h_ok  = h_scl_r | scl_s;   // high phase waits while another node stretches
    wire h_adv = (tmr_r == 16'h0000) & h_ok;                // R20
    always_comb begin
        h_state_nxt = h_state_r;
        stp_nxt     = stp_r;
        bcnt_nxt    = bcnt_r;
        h_sh_nxt    = h_sh_r;
        h_rx_nxt    = h_rx_r;
        h_scl_nxt   = h_scl_r;
        h_sda_nxt   = h_sda_r;
        h_done_st   = 1'b0;
        h_done_rs   = 1'b0;
        h_done_sp   = 1'b0;
        h_done_ak   = 1'b0;
        h_done_rx   = 1'b0;
        h_take      = 1'b0;
        h_nack_ld   = 1'b0;
        h_rx_val    = {h_sh_r[6:0], sda_s};
        tmr_nxt     = h_adv ? baud_r : ((h_ok && tmr_r != 16'h0000) ? tmr_r - 16'h0001 : tmr_r);
        if (h_adv) stp_nxt = stp_r + 2'b01;
        case (h_state_r)
            H_IDLE: begin
                tmr_nxt = baud_r;                            // R20
                stp_nxt = 2'b00;
                bcnt_nxt = 4'h0;
                if (ctrl_r.start_go) h_state_nxt = H_START;  // R19
                else if (ctrl_r.restart_go) h_state_nxt = H_RESTART;
                else if (ctrl_r.stop_go) h_state_nxt = H_STOP;
                else if (ctrl_r.ack_sequence_go) h_state_nxt = H_ACK; // R16
                else if (ctrl_r.receive_go) begin            // R18
                    h_state_nxt = H_XFER;
                    h_rx_nxt = 1'b1;
                end else if (tbf_r) begin
                    h_state_nxt = H_XFER;                    // R1
                    h_rx_nxt = 1'b0;
                    h_sh_nxt = tx_r[7:0]; // R10
                    h_take = 1'b1;
                end
            end
            H_START: if (h_adv) begin                        // R19
                if (stp_r == 2'b00) h_sda_nxt = 1'b1;
                else begin
                    h_scl_nxt = 1'b1;
                    h_done_st = 1'b1;
                    h_state_nxt = H_IDLE;
                end
            end
            H_RESTART: if (h_adv) begin                      // R19
                case (stp_r)
                    2'b00: h_sda_nxt = 1'b0;
                    2'b01: h_scl_nxt = 1'b0;
                    2'b10: h_sda_nxt = 1'b1;
                    default: begin
                        h_scl_nxt = 1'b1;
                        h_done_rs = 1'b1;
                        h_state_nxt = H_IDLE;
                    end
                endcase
            end
            H_STOP: begin                                    // R19
                if (stp_r == 2'b00 && !scl_s) h_sda_nxt = 1'b1;
                if (h_adv) begin
                    if (stp_r == 2'b00) h_scl_nxt = 1'b0;
                    else begin
                        h_sda_nxt = 1'b0;
                        h_done_sp = 1'b1;
                        h_state_nxt = H_IDLE;
                    end
                end
            end
            H_XFER: begin
                // data moves only once the wire is seen low: hold time on sda
                if (!stp_r[0] && !scl_s) h_sda_nxt = ~(h_rx_r | bcnt_r == BIT_ACK) & ~h_sh_r[7];
                if (h_adv) begin
                    stp_nxt = {1'b0, ~stp_r[0]};
                    h_scl_nxt = stp_r[0];
                    if (stp_r[0]) begin
                        bcnt_nxt = bcnt_r + 4'h1;
                        if (bcnt_r == BIT_ACK) h_nack_ld = 1'b1;
                        else h_sh_nxt = h_rx_val;
                        if (h_rx_r && bcnt_r == BIT_LAST) begin
                            h_done_rx = 1'b1;                // R18
                            h_state_nxt = H_IDLE;
                        end else if (!h_rx_r && bcnt_r == BIT_ACK) h_state_nxt = H_IDLE;
                    end
                end
            end
            H_ACK: begin
                if (!stp_r[0] && !scl_s) h_sda_nxt = ~ctrl_r.ack_level; // R14
                if (h_adv) begin
                    h_scl_nxt = stp_r[0];
                    if (stp_r[0]) begin
                        h_done_ak = 1'b1;                    // R16
                        h_state_nxt = H_IDLE;
                    end
                end
            end
            default: h_state_nxt = H_IDLE;
        endcase
        if (!run || !host) begin
            h_state_nxt = H_IDLE;
            h_scl_nxt = 1'b0;
            h_sda_nxt = 1'b0;
        end
    end

    // client address recognition on the byte just shifted in
    wire rsv7   = (c_sh_r[7:4] == RSV_LO) | (c_sh_r[7:4] == RSV_HI);
    wire is_gc  = (c_sh_r == GCALL_BYTE);
    wire hdr_ok = (c_sh_r[7:3] == HDR10) & (c_sh_r[2:1] == own_r[9:8]);
    wire wide   = ctrl_r.wide_address_sel;                  // R12
    wire m7     = (c_sh_r[7:1] == own_r[6:0]) & ~(ctrl_r.strict_addr & rsv7); // R9 R11
    wire a_ok   = is_gc ? ctrl_r.general_call_accept :      // R13
                  wide ? (hdr_ok & (~c_sh_r[0] | c_wide_r)) : m7;
    wire ackv   = aux_r.address_hold ? ctrl_r.ack_level : 1'b0; // R15

    always_comb begin
        c_state_nxt = c_state_r;
        c_after_nxt = c_after_r;
        c_sh_nxt    = c_sh_r;
        ccnt_nxt    = ccnt_r;
        c_sda_nxt   = c_sda_r;
        c_wide_nxt  = c_wide_r;
        c_mack_nxt  = c_mack_r;
        c_rx_ld     = 1'b0;
        c_take      = 1'b0;
        c_gc        = 1'b0;
        c_relclr    = 1'b0;
        if (scl_rise) ccnt_nxt = ccnt_r + 4'h1;
        case (c_state_r)
            C_ADDR, C_ADDR2, C_RX: begin
                if (scl_rise) c_sh_nxt = {c_sh_r[6:0], sda_s};
                if (scl_fall && ccnt_r == BIT_ACK) begin
                    c_state_nxt = C_ACK;
                    if (c_state_r == C_RX) begin
                        c_rx_ld = 1'b1;
                        c_sda_nxt = ~(aux_r.data_hold & ctrl_r.ack_level); // R15
                        c_relclr = ctrl_r.stretch_allow | aux_r.data_hold;  // R7
                        c_after_nxt = C_RX;
                    end else if (c_state_r == C_ADDR2) begin
                        c_sda_nxt = (c_sh_r == own_r[7:0]) & ~ackv;
                        c_relclr = aux_r.address_hold;
                        c_wide_nxt = (c_sh_r == own_r[7:0]);
                        c_after_nxt = (c_sh_r == own_r[7:0]) ? C_RX : C_IDLE;
                    end else begin
                        c_sda_nxt = a_ok & ~ackv;
                        c_relclr = a_ok & aux_r.address_hold;
                        c_gc = a_ok & is_gc;                  // R13
                        c_after_nxt = !a_ok ? C_IDLE : c_sh_r[0] ? C_TX :
                                      (wide && !is_gc) ? C_ADDR2 : C_RX;
                    end
                end
            end
            C_ACK: if (scl_fall) begin
                ccnt_nxt = 4'h0;
                c_state_nxt = c_after_r;
                c_sda_nxt = 1'b0;
                if (c_after_r == C_TX) begin
                    c_sh_nxt = tx_r[7:0];                     // R1
                    c_sda_nxt = ~tx_r[7];
                    c_take = 1'b1;
                    c_relclr = 1'b1;                          // R7
                end
            end
            C_TX: if (scl_fall) begin
                if (ccnt_r == BIT_ACK) begin
                    c_sda_nxt = 1'b0;
                    c_state_nxt = C_TXACK;
                end else begin
                    c_sh_nxt = {c_sh_r[6:0], 1'b0};
                    c_sda_nxt = ~c_sh_r[6];
                end
            end
            C_TXACK: begin
                if (scl_rise) c_mack_nxt = ~sda_s;
                if (scl_fall) begin
                    c_state_nxt = C_ACK;
                    c_after_nxt = c_mack_r ? C_TX : C_IDLE;
                    c_sda_nxt = 1'b0;
                end
            end
            default: c_sda_nxt = 1'b0;
        endcase
        if (start_det) begin
            c_state_nxt = C_ADDR;
            ccnt_nxt = 4'h0;
            c_sda_nxt = 1'b0;
        end
        if (stop_det || !run || host) begin
            c_state_nxt = C_IDLE;
            c_sda_nxt = 1'b0;
            c_wide_nxt = 1'b0;
        end
    end

    // client clock hold: with stretching it starts at the next low phase
    wire c_act  = (c_state_r != C_IDLE);
    wire c_hold = c_act & ~ctrl_r.clock_release
                & (c_hold_r | ~scl_s | ~ctrl_r.stretch_allow); // R5 R6
    assign scl_pin.low = run & (host ? h_scl_r : c_hold);
    assign scl_pin.oe  = scl_pin.low;
    assign sda_pin.low = run & (host ? h_sda_r : c_sda_r);
    assign sda_pin.oe  = sda_pin.low;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_r <= RST_CTRL;
            aux_r  <= RST_AUX;
            tx_r   <= RST_TX;
            baud_r <= RST_BAUD;
            own_r  <= RST_OWN;
        end else begin
            ctrl_r <= ctrl_nxt;
            if (wr && hit_aux) aux_r <= merge(aux_r, wmask, wb_dat_i[15:0]);
            if (wr && hit_tx) tx_r <= merge(tx_r, wmask, {8'h00, wb_dat_i[7:0]}); // R1
            if (wr && hit_brg) baud_r <= merge(baud_r, wmask, wb_dat_i[15:0]);    // R2
            if (wr && hit_own) own_r <= 10'(merge({6'h00, own_r}, wmask, wb_dat_i[15:0]));
        end
    end

    // flags: a hardware set in the same cycle as its clear wins
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tbf_r  <= 1'b0;
            rbf_r  <= 1'b0;
            nack_r <= 1'b0;
            gcs_r  <= 1'b0;
            rx_r   <= RST_RX;
        end else begin
            tbf_r  <= (wr & hit_tx & wb_sel_i[0]) | (tbf_r & ~h_take & ~c_take);
            rbf_r  <= h_done_rx | c_rx_ld | (rbf_r & ~(rd & hit_rx));
            gcs_r  <= c_gc | (gcs_r & ~stop_det);
            if (h_nack_ld) nack_r <= sda_s;
            if (h_done_rx) rx_r <= h_rx_val;
            else if (c_rx_ld) rx_r <= c_sh_r;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            h_state_r <= H_IDLE;
            c_state_r <= C_IDLE;
            c_after_r <= C_IDLE;
            stp_r     <= 2'b00;
            bcnt_r    <= 4'h0;
            ccnt_r    <= 4'h0;
            tmr_r     <= RST_BAUD;
            h_sh_r    <= 8'h00;
            c_sh_r    <= 8'h00;
            {h_rx_r, h_scl_r, h_sda_r, c_sda_r, c_hold_r, c_wide_r, c_mack_r} <= 7'h00;
            {scl_q, sda_q} <= 2'b11;
        end else begin
            h_state_r <= h_state_nxt;
            c_state_r <= c_state_nxt;
            c_after_r <= c_after_nxt;
            stp_r     <= stp_nxt;
            bcnt_r    <= bcnt_nxt;
            ccnt_r    <= ccnt_nxt;
            tmr_r     <= tmr_nxt;
            h_sh_r    <= h_sh_nxt;
            c_sh_r    <= c_sh_nxt;
            {h_rx_r, h_scl_r, h_sda_r} <= {h_rx_nxt, h_scl_nxt, h_sda_nxt};
            {c_sda_r, c_hold_r, c_wide_r, c_mack_r} <= {c_sda_nxt, c_hold, c_wide_nxt, c_mack_nxt};
            {scl_q, sda_q} <= {scl_s, sda_s};
        end
    end

    // registered outputs; pins are open drain, drive value is always low
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_r        <= 1'b0;
            wb_dat_o     <= 32'h0000_0000;
            scl_o        <= 1'b0;
            sda_o        <= 1'b0;
            scl_oe_o     <= 1'b0;
            sda_oe_o     <= 1'b0;
            pins_owned_o <= 1'b0;
            gc_event_o   <= 1'b0;
        end else begin
            ack_r        <= acc;
            wb_dat_o     <= rd ? {16'h0000, rd_mux} : 32'h0000_0000;
            scl_o        <= 1'b0;
            sda_o        <= 1'b0;
            scl_oe_o     <= scl_pin.oe;
            sda_oe_o     <= sda_pin.oe;
            pins_owned_o <= ctrl_r.module_on;                // R3
            gc_event_o   <= c_gc;                            // R13
        end
    end
    assign wb_ack_o = ack_r;
    wire unused_ok = &{1'b0, rd_low};
endmodule : i2cpc_top
`default_nettype wire

// >>> i2cpc_chk.sv
// assertions on the bus answer, pin release and general call pulse
`timescale 1ns/1ps
`default_nettype none
module i2cpc_chk (
    input wire logic        clk_i,        // clock
    input wire logic        rst_i,        // reset
    input wire logic        wb_cyc_i,     // cycle
    input wire logic        wb_stb_i,     // strobe
    input wire logic        wb_ack_o,     // ack
    input wire logic [31:0] wb_dat_o,     // read data
    input wire logic        scl_oe_o,     // clock pull
    input wire logic        sda_oe_o,     // data pull
    input wire logic        pins_owned_o, // enabled
    input wire logic        gc_event_o    // general call
);
    default clocking @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    ack_resp_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("request not answered");
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than a cycle");
    ack_cause_a: assert property (wb_ack_o |-> $past(wb_stb_i))
        else $error("ack without request");
    dat_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h00000000)
        else $error("read data outside ack");
    dat_upper_a: assert property (wb_dat_o[31:16] == 16'h0000)
        else $error("upper read bits set");
    // engines need a cycle to fall idle after disable
    pins_rel_a: assert property (!pins_owned_o [*3] |-> !scl_oe_o && !sda_oe_o)
        else $error("pins pulled while disabled");
    gc_pulse_a: assert property (gc_event_o |=> !gc_event_o)
        else $error("general call pulse too long");
    gc_owned_a: assert property (gc_event_o |-> pins_owned_o)
        else $error("general call while disabled");
    cover property (wb_ack_o);
    cover property (gc_event_o);
    cover property (sda_oe_o && !scl_oe_o ##1 scl_oe_o);
endmodule : i2cpc_chk
bind i2cpc_top i2cpc_chk u_chk (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o), .scl_oe_o(scl_oe_o),
    .sda_oe_o(sda_oe_o), .pins_owned_o(pins_owned_o), .gc_event_o(gc_event_o));
`default_nettype wire

// >>> i2cpc_peer.sv
// remote host node on the two-wire bus, lines pulled up
`timescale 1ns/1ps
`default_nettype none
module i2cpc_peer (
    input  wire logic dev_scl_i, // device pulls clock
    input  wire logic dev_sda_i, // device pulls data
    output wire logic scl_o,     // clock wire
    output wire logic sda_o      // data wire
);
    logic pscl = 1'b0;
    logic psda = 1'b0;
    assign scl_o = !(pscl || dev_scl_i);
    assign sda_o = !(psda || dev_sda_i);
    // clock idles high between frames; last bit released for ack
    task automatic frame(input logic [8:0] b, output logic ack);
        #10 psda = 1'b1;
        #160 pscl = 1'b1;
        for (int i = 8; i >= 0; i--) begin
            #40 psda = ~b[i];
            #120 pscl = 1'b0;
            wait (scl_o);
            #80 ack = sda_o;
            #80 pscl = 1'b1;
        end
        #40 psda = 1'b1;
        #120 pscl = 1'b0;
        #160 psda = 1'b0;
    endtask : frame
endmodule : i2cpc_peer
`default_nettype wire

// >>> i2cpc_tb.sv
// bench: client address decisions, registers, host start timing
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import i2cpc_pkg::*;
    localparam logic [13:0] CTL = {IDX_CTRL, 2'b00};
    logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, idle = 1'b0;
    logic ack, scl, sda, scl_oe, sda_oe, gc, a, gc_seen = 1'b0;
    logic [13:0] adr = 14'h0000;
    logic [3:0] sel = 4'h0;
    logic [31:0] dat = 32'h00000000, rdat;
    logic [15:0] q;
    logic [35:0] rows [7] = '{{10'h055, 16'h9000, 8'hAA, 2'b00},
        {10'h055, 16'h9080, 8'h00, 2'b01}, {10'h055, 16'h9000, 8'h00, 2'b10},
        {10'h003, 16'h9800, 8'h06, 2'b10}, {10'h003, 16'h9000, 8'h06, 2'b00},
        {10'h055, 16'h9400, 8'hAA, 2'b10}, {10'h055, 16'h1080, 8'h00, 2'b10}};
    int miscompares = 0, n_checks = 0, cyc_cnt = 0, gap = 0;
    always #20 clk_i = ~clk_i;
    i2cpc_top u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat),
        .wb_ack_o(ack), .scl_i(scl), .scl_o(), .scl_oe_o(scl_oe), .sda_i(sda), .sda_o(),
        .sda_oe_o(sda_oe), .cpu_idle_i(idle), .pins_owned_o(), .gc_event_o(gc));
    i2cpc_peer u_peer (.dev_scl_i(scl_oe), .dev_sda_i(sda_oe), .scl_o(scl), .sda_o(sda));
    always @(posedge clk_i) if (gc === 1'b1) gc_seen <= 1'b1;
    always @(posedge clk_i) if (sda_oe === 1'b1 && scl_oe === 1'b0) gap <= gap + 1;
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk
    task automatic print_verdict;
        if (miscompares == 0 && n_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : print_verdict
    task automatic wb(input logic w, input logic [13:0] ad, input logic [15:0] d);
        @(posedge clk_i);
        {cyc, stb, we, adr, sel, dat} <= {2'b11, w, ad, 4'h3, 16'h0000, d};
        do @(posedge clk_i); while (ack !== 1'b1);
        q = rdat[15:0];
        {cyc, stb} <= 2'b00;
    endtask : wb
    // go bits clear only when the operation completes, so the control word is polled
    task automatic poll(input logic [15:0] d);
        int k = 0;
        wb(1'b1, CTL, d);
        do wb(1'b0, CTL, 16'h0000); while (q !== 16'h8000 && ++k < 100);
    endtask : poll
    always @(posedge clk_i) begin
        cyc_cnt++;
        if (cyc_cnt >= 20000) begin
            miscompares++;
            print_verdict();
        end
    end
    initial begin
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        foreach (rows[i]) begin
            wb(1'b1, {IDX_OWN_ADDR, 2'b00}, {6'h00, rows[i][35:26]});
            wb(1'b1, CTL, rows[i][25:10]);
            gc_seen = 1'b0;
            u_peer.frame({rows[i][9:2], 1'b1}, a);
            chk(16'(a), 16'(rows[i][1]));
            chk(16'(gc_seen), 16'(rows[i][0]));
        end
        rst_i <= 1'b1;
        @(posedge clk_i);
        rst_i <= 1'b0;
        wb(1'b0, {IDX_TX, 2'b00}, 16'h0000);
        chk(q, RST_TX);
        wb(1'b0, CTL, 16'h0000);
        chk(q, RST_CTRL);
        wb(1'b1, {IDX_TX, 2'b00}, 16'h005A);
        wb(1'b0, {IDX_TX, 2'b00}, 16'h0000);
        chk(q, 16'h005A);
        wb(1'b0, 14'h1300, 16'h0000);
        chk(q, 16'h0000);
        wb(1'b1, {IDX_BAUD, 2'b00}, 16'h0003);
        wb(1'b0, {IDX_BAUD, 2'b00}, 16'h0000);
        chk(q, 16'h0003);
        wb(1'b1, {IDX_AUX, 2'b00}, 16'h0001);
        gap = 0;
        poll(16'h8001);
        chk(q, 16'h8000);
        chk(16'(gap), 16'h0004);
        poll(16'h8004);
        chk(q, 16'h8000);
        poll(16'h8008);
        chk(q, 16'h8000);
        poll(16'h8010);
        chk(q, 16'h8000);
        wb(1'b1, CTL, 16'hA000);
        idle <= 1'b1;
        wb(1'b1, CTL, 16'hA001);
        repeat (20) @(posedge clk_i);
        chk(16'(sda_oe), 16'h0000);
        print_verdict();
    end
endmodule : testbench
`default_nettype wire
